/* ers_consts.vh */
/*
 * constants for the e1 receive sync and alarm status bank:
 * register offsets, bit positions, reset values and timing counts.
 * assumes a 200 MHz system clock and a 125 us e1 frame.
 */
`ifndef ERS_CONSTS_VH
`define ERS_CONSTS_VH

// ----------------------------------------------------------------
// register offsets (5-bit page address)
// ----------------------------------------------------------------
`define ERS_A_SYNC_STATUS      5'h10
`define ERS_A_ALARM_FIRST      5'h11
`define ERS_A_TIMER_STATUS     5'h12
`define ERS_A_SLIP_UPPER       5'h13
`define ERS_A_SLIP_LOWER       5'h14
`define ERS_A_RX_FAS           5'h15
`define ERS_A_RX_LINE_STATUS   5'h16
`define ERS_A_JA_STATUS        5'h17
`define ERS_A_RX_NFAS          5'h18
`define ERS_A_RX_MFAS          5'h19
`define ERS_A_CONTROL          5'h1A
`define ERS_A_ALARM_SECOND     5'h1B
`define ERS_A_IRQ_STATUS       5'h1C
`define ERS_A_IRQ_MASK         5'h1D
`define ERS_A_DEVICE_IDENT     5'h1F

// ----------------------------------------------------------------
// control register fields and reset
// ----------------------------------------------------------------
`define ERS_CTL_AIS_SEL        0
`define ERS_CTL_MAINT          1
`define ERS_CTL_AUTO_IWK       2
`define ERS_CTL_RESET          8'h04

// ----------------------------------------------------------------
// interrupt event bits
// ----------------------------------------------------------------
`define ERS_EV_FRAME_LOST      0
`define ERS_EV_RED             1
`define ERS_EV_CRC_REFRAME     2
`define ERS_EV_SUBMF_ERR       3
`define ERS_EV_REMOTE_CRC4_FAILURE           4
`define ERS_EV_LOS             5
`define ERS_EV_AIS16           6
`define ERS_EV_AIS             7

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define ERS_CLK_PERIOD_PS      5000
`define ERS_FRAME_PS           125000000
`define ERS_FRAME_TICKS        (`ERS_FRAME_PS / `ERS_CLK_PERIOD_PS)
`define ERS_FRAME_US           125
`define ERS_CRC_TMO_MS         8
`define ERS_CRC_TMO_FRAMES     ((`ERS_CRC_TMO_MS * 1000 + `ERS_FRAME_US - 1) / `ERS_FRAME_US)
`define ERS_RED_MS             100
`define ERS_RED_FRAMES         ((`ERS_RED_MS * 1000 + `ERS_FRAME_US - 1) / `ERS_FRAME_US)
`define ERS_SEC_MS             1000
`define ERS_SEC_FRAMES         ((`ERS_SEC_MS * 1000) / `ERS_FRAME_US)
`define ERS_REMOTE_CRC4_FAILURE_SECS         3'h5
`define ERS_EBIT_LIMIT         10'd989
`define ERS_LOS_BITS           8'd192
`define ERS_LOS_ONES_MIN       8'd24
`define ERS_AIS_WIN_LONG       10'd512
`define ERS_AIS_WIN_SHORT      10'd256
`define ERS_AIS_ZEROS_MAX      10'd3

`endif

/* ers_status_bank.v */
/*
 * e1 receive sync and alarm status bank: alignment, e-bit, crc-4
 * reframe and interworking, red alarm, submultiframe crc errors,
 * remote crc-4 failure, loss of signal, ais and ais16 detection,
 * with a small sticky interrupt block and a plain register port.
 * assumes every framer input is on I_CLK and is one-cycle-pulsed
 * where named _STB; the framer acts on O_REFRAME.
 */
// The strobed register port was chosen for this implementation.
// Contract
// [R01] sync bit 7 high while basic frame alignment lost, low once acquired
// [R02] sync bit 6 reports multiframe alignment, one means lost
// [R03] sync bit 5 reports crc-4 multiframe alignment, one means lost
// [R04] sync bits 4 and 3 hold last multiframe's first and second e-bit
// [R05] sync bit 2 set when crc-4 multiframe unfound 8 ms after frame sync
// [R06] reframe forced on that timeout if maintenance on, auto interworking off
// [R07] red alarm after 100 ms frame loss, cleared when alignment regained
// [R08] sync bit 0 interworking: one crc-to-crc, zero crc-to-non-crc
// [R09] alarm bits 7/6 show crc error of last submultiframe 1/2
// [R10] remote failure only after five seconds of e-errors>989, no rai, sync
// [R11] loss of signal after 192 zero bits, shown in alarm bit 4
// [R12] loss ends on 12.5% ones over 192 positions starting on a pulse
// [R13] alarm bit 3 while channel 16 all ones, re-evaluated each frame
// [R14] alarm bit 2 while valid ais, criterion chosen by select bit
// [R15] writes to status addresses ignored, reads return live status
`timescale 1ns/1ps
`include "ers_consts.vh"

module ers_status_bank #(
	parameter FRAME_TICKS = `ERS_FRAME_TICKS,
	parameter SEC_FRAMES  = `ERS_SEC_FRAMES,
	parameter [7:0] DEVICE_ID = 8'h5A // arbitrary value
) (
	// clock and reset
	input  wire       I_CLK,
	input  wire       I_RST_N,
	// register port
	input  wire [4:0] I_ADDR,
	input  wire [7:0] I_WDATA,
	input  wire       I_WR,
	input  wire       I_RD,
	output reg  [7:0] O_RDATA,
	// received line, one strobe per bit period
	input  wire       I_BIT_STB,
	input  wire       I_RX_BIT,
	// framer state
	input  wire       I_FRAME_STB,
	input  wire       I_BFA_OK,
	input  wire       I_MFA_OK,
	input  wire       I_CRC_MFA_OK,
	input  wire       I_RAI,
	input  wire       I_TS16_ONES,
	// e-bits, per multiframe
	input  wire       I_EBIT_STB,
	input  wire       I_EBIT1,
	input  wire       I_EBIT2,
	input  wire       I_EBIT_ERR,
	// submultiframe crc result
	input  wire       I_SMF_STB,
	input  wire       I_SMF_SEL,
	input  wire       I_SMF_CRC_ERR,
	// outputs
	output reg        O_REFRAME,
	output reg        O_IRQ
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	reg  [7:0]  ctl;
	reg  [7:0]  irq_stat;
	reg  [7:0]  irq_mask;
	reg  [15:0] tick_cnt;
	reg         frame_tick;
	reg         bfa_q;
	reg         rx_ebit_first;
	reg         rx_ebit_second;
	reg  [6:0]  crc_tmo_cnt;
	reg         crc_tmo_run;
	reg         crc4_reframe_flag;
	reg         crc4_interwork_state;
	reg  [9:0]  red_cnt;
	reg         frame_loss_alarm;
	reg         submf_a_crc_error;
	reg         submf_b_crc_error;
	reg  [15:0] sec_cnt;
	reg  [9:0]  ebit_cnt;
	reg         sec_bad;
	reg  [2:0]  good_secs;
	reg         remote_crc4_failure;
	reg  [7:0]  zero_run;
	reg         los;
	reg         los_win;
	reg  [7:0]  los_pos;
	reg  [7:0]  los_ones;
	reg  [9:0]  ais_pos;
	reg  [9:0]  ais_zeros;
	reg         line_all_ones_alarm;
	reg         chan16_all_ones_alarm;

	wire        ais_criterion_select = ctl[`ERS_CTL_AIS_SEL];
	wire        frame_lost = ~I_BFA_OK;
	wire        multiframe_lost = ~I_MFA_OK;
	wire        crc4_multiframe_lost = ~I_CRC_MFA_OK;
	wire        crc_timeout = crc_tmo_run && I_CRC_MFA_OK == 1'b0 && frame_tick &&
	                          crc_tmo_cnt == `ERS_CRC_TMO_FRAMES - 1;
	wire [9:0]  ais_win = ais_criterion_select ? `ERS_AIS_WIN_SHORT : `ERS_AIS_WIN_LONG;
	wire        sec_end = frame_tick && sec_cnt == SEC_FRAMES - 1;
	wire [7:0]  events;
	reg  [7:0]  next_rdata;

	// ------------------------------------------------------------
	// frame time base
	// ------------------------------------------------------------
	// free running so timers keep counting while alignment is lost
	always @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			tick_cnt   <= 16'h0000;
			frame_tick <= 1'b0;
		end else if (tick_cnt == FRAME_TICKS - 1) begin
			tick_cnt   <= 16'h0000;
			frame_tick <= 1'b1;
		end else begin
			tick_cnt   <= tick_cnt + 16'h0001;
			frame_tick <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// e-bits and submultiframe crc results
	// ------------------------------------------------------------
	always @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			rx_ebit_first     <= 1'b0;
			rx_ebit_second    <= 1'b0;
			submf_a_crc_error <= 1'b0;
			submf_b_crc_error <= 1'b0;
		end else begin
			if (I_EBIT_STB) begin
				rx_ebit_first  <= I_EBIT1;          // R04
				rx_ebit_second <= I_EBIT2;          // R04
			end
			if (I_SMF_STB && !I_SMF_SEL)
				submf_a_crc_error <= I_SMF_CRC_ERR; // R09
			if (I_SMF_STB && I_SMF_SEL)
				submf_b_crc_error <= I_SMF_CRC_ERR; // R09
		end
	end

	// ------------------------------------------------------------
	// crc-4 search timeout, reframe and interworking
	// ------------------------------------------------------------
	// timer armed on each basic frame alignment gain
	always @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			bfa_q                <= 1'b0;
			crc_tmo_cnt          <= 7'h00;
			crc_tmo_run          <= 1'b0;
			crc4_reframe_flag    <= 1'b0;
			crc4_interwork_state <= 1'b0;
			O_REFRAME            <= 1'b0;
		end else begin
			bfa_q     <= I_BFA_OK;
			O_REFRAME <= 1'b0;
			if (I_BFA_OK && !bfa_q) begin
				crc_tmo_run <= 1'b1;
				crc_tmo_cnt <= 7'h00;
			end else if (!I_BFA_OK || I_CRC_MFA_OK) begin
				crc_tmo_run <= 1'b0;
			end else if (crc_timeout) begin
				crc_tmo_run <= 1'b0;
			end else if (crc_tmo_run && frame_tick) begin
				crc_tmo_cnt <= crc_tmo_cnt + 7'h01;
			end
			if (crc_timeout) begin
				crc4_reframe_flag <= 1'b1;                         // R05
				if (ctl[`ERS_CTL_AUTO_IWK])
					crc4_interwork_state <= 1'b0;                  // R08
				if (ctl[`ERS_CTL_MAINT] && !ctl[`ERS_CTL_AUTO_IWK])
					O_REFRAME <= 1'b1;                             // R06
			end else if (I_CRC_MFA_OK) begin
				crc4_reframe_flag    <= 1'b0;
				crc4_interwork_state <= 1'b1;                      // R08
			end
		end
	end

	// ------------------------------------------------------------
	// red alarm
	// ------------------------------------------------------------
	// one tick beyond the hold count, so a loss that begins just before
	// a free-running tick can never raise the alarm short of the hold time
	always @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			red_cnt          <= 10'h000;
			frame_loss_alarm <= 1'b0;
		end else if (I_BFA_OK) begin
			red_cnt          <= 10'h000;
			frame_loss_alarm <= 1'b0;                              // R07
		end else if (frame_tick) begin
			if (red_cnt == `ERS_RED_FRAMES)
				frame_loss_alarm <= 1'b1;                          // R07
			else
				red_cnt <= red_cnt + 10'h001;
		end
	end

	// ------------------------------------------------------------
	// remote crc-4 failure, judged once per second
	// ------------------------------------------------------------
	// error count saturates just above the limit; only "exceeded" matters
	always @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			sec_cnt             <= 16'h0000;
			ebit_cnt            <= 10'h000;
			sec_bad             <= 1'b0;
			good_secs           <= 3'h0;
			remote_crc4_failure <= 1'b0;
		end else if (sec_end) begin
			sec_cnt  <= 16'h0000;
			ebit_cnt <= 10'h000;
			sec_bad  <= 1'b0;
			if (sec_bad || I_RAI || !I_BFA_OK || ebit_cnt <= `ERS_EBIT_LIMIT) begin
				good_secs           <= 3'h0;
				remote_crc4_failure <= 1'b0;
			end else if (good_secs >= `ERS_REMOTE_CRC4_FAILURE_SECS - 3'h1) begin
				good_secs           <= `ERS_REMOTE_CRC4_FAILURE_SECS;
				remote_crc4_failure <= 1'b1;                       // R10
			end else begin
				good_secs <= good_secs + 3'h1;
			end
		end else begin
			if (frame_tick)
				sec_cnt <= sec_cnt + 16'h0001;
			if (I_EBIT_ERR && ebit_cnt <= `ERS_EBIT_LIMIT)
				ebit_cnt <= ebit_cnt + 10'h001;
			if (I_RAI || !I_BFA_OK)
				sec_bad <= 1'b1;                                   // R10
		end
	end

	// ------------------------------------------------------------
	// loss of signal
	// ------------------------------------------------------------
	always @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			zero_run <= 8'h00;
			los      <= 1'b0;
			los_win  <= 1'b0;
			los_pos  <= 8'h00;
			los_ones <= 8'h00;
		end else if (I_BIT_STB) begin
			if (I_RX_BIT)
				zero_run <= 8'h00;
			else if (zero_run != `ERS_LOS_BITS)
				zero_run <= zero_run + 8'h01;
			if (!los) begin
				los_win <= 1'b0;
				if (!I_RX_BIT && zero_run == `ERS_LOS_BITS - 8'h01)
					los <= 1'b1;                                   // R11
			end else if (!los_win) begin
				if (I_RX_BIT) begin
					los_win  <= 1'b1;                              // R12
					los_pos  <= 8'h01;
					los_ones <= 8'h01;
				end
			end else if (los_pos == `ERS_LOS_BITS - 8'h01) begin
				los_win <= 1'b0;
				if (los_ones + {7'h00, I_RX_BIT} >= `ERS_LOS_ONES_MIN)
					los <= 1'b0;                                   // R12
			end else begin
				los_pos  <= los_pos + 8'h01;
				los_ones <= los_ones + {7'h00, I_RX_BIT};
			end
		end
	end

	// ------------------------------------------------------------
	// ais on the line and in channel 16
	// ------------------------------------------------------------
	// fewer than three zeros per window; select picks one or two frames
	always @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			ais_pos               <= 10'h000;
			ais_zeros             <= 10'h000;
			line_all_ones_alarm   <= 1'b0;
			chan16_all_ones_alarm <= 1'b0;
		end else begin
			if (I_FRAME_STB)
				chan16_all_ones_alarm <= I_TS16_ONES;              // R13
			if (I_BIT_STB) begin
				if (ais_pos >= ais_win - 10'h001) begin
					ais_pos   <= 10'h000;
					ais_zeros <= 10'h000;
					line_all_ones_alarm <=
						(ais_zeros + {9'h000, ~I_RX_BIT}) < `ERS_AIS_ZEROS_MAX; // R14
				end else begin
					ais_pos   <= ais_pos + 10'h001;
					ais_zeros <= ais_zeros + {9'h000, ~I_RX_BIT};
				end
			end
		end
	end

	// ------------------------------------------------------------
	// interrupt events: rising edges of each alarm except I_RAI, plus each submultiframe crc error strobe
	// ------------------------------------------------------------
	reg [7:0] ev_lvl_q;
	wire [7:0] ev_lvl = {line_all_ones_alarm, chan16_all_ones_alarm, los,
	                     remote_crc4_failure, 1'b0, crc4_reframe_flag,
	                     frame_loss_alarm, frame_lost};
	assign events = (ev_lvl & ~ev_lvl_q) |
	                {4'h0, I_SMF_STB & I_SMF_CRC_ERR, 3'h0};

	// set wins over a write-one-to-clear in the same cycle
	always @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			ev_lvl_q <= 8'h00;
			irq_stat <= 8'h00;
			O_IRQ    <= 1'b0;
		end else begin
			ev_lvl_q <= ev_lvl;
			if (I_WR && I_ADDR == `ERS_A_IRQ_STATUS)
				irq_stat <= (irq_stat & ~I_WDATA) | events;
			else
				irq_stat <= irq_stat | events;
			O_IRQ <= |(irq_stat & irq_mask);
		end
	end

	// ------------------------------------------------------------
	// register writes
	// ------------------------------------------------------------
	// only control and mask take writes here; interrupt status is write-one-to-clear above, other status addresses ignore them
	always @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			ctl      <= `ERS_CTL_RESET;
			irq_mask <= 8'h00;
		end else if (I_WR) begin
			if (I_ADDR == `ERS_A_CONTROL)
				ctl <= {5'h00, I_WDATA[2:0]};
			else if (I_ADDR == `ERS_A_IRQ_MASK)
				irq_mask <= I_WDATA;                               // R15
		end
	end

	// ------------------------------------------------------------
	// read decode
	// ------------------------------------------------------------
	always @* begin
		next_rdata = 8'h00;
		if (I_ADDR == `ERS_A_SYNC_STATUS)
			next_rdata = {frame_lost,                              // R01
			              multiframe_lost,                         // R02
			              crc4_multiframe_lost,                    // R03
			              rx_ebit_first, rx_ebit_second,           // R04
			              crc4_reframe_flag,                       // R05
			              frame_loss_alarm,                        // R07
			              crc4_interwork_state};                   // R08
		else if (I_ADDR == `ERS_A_ALARM_FIRST)
			next_rdata = {submf_a_crc_error, submf_b_crc_error,   // R09
			              remote_crc4_failure,                     // R10
			              los,                                     // R11
			              chan16_all_ones_alarm,                   // R13
			              line_all_ones_alarm,                     // R14
			              I_RAI, 1'b0};
		else if (I_ADDR == `ERS_A_CONTROL)
			next_rdata = ctl;
		else if (I_ADDR == `ERS_A_IRQ_STATUS)
			next_rdata = irq_stat;
		else if (I_ADDR == `ERS_A_IRQ_MASK)
			next_rdata = irq_mask;
		else if (I_ADDR == `ERS_A_DEVICE_IDENT)
			next_rdata = DEVICE_ID;
	end

	// read data valid only in the cycle after the read strobe
	always @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N)
			O_RDATA <= 8'h00;
		else if (I_RD)
			O_RDATA <= next_rdata;                                 // R15
		else
			O_RDATA <= 8'h00;
	end

endmodule // ers_status_bank

/* ers_status_bank_props.sv */
/*
 * checker for the e1 status bank: read data against framer inputs.
 * assumes one clock and read data in the cycle after a read strobe.
 */
`timescale 1ns/1ps
module ers_status_bank_props (
	// clock, reset and register port
	input wire       I_CLK,
	input wire       I_RST_N,
	input wire [4:0] I_ADDR,
	input wire       I_RD,
	input wire [7:0] O_RDATA,
	// framer side
	input wire       I_BIT_STB,
	input wire       I_RX_BIT,
	input wire       I_FRAME_STB,
	input wire       I_BFA_OK,
	input wire       I_MFA_OK,
	input wire       I_CRC_MFA_OK,
	input wire       I_TS16_ONES,
	input wire       I_EBIT_STB,
	input wire       I_EBIT1,
	input wire       I_EBIT2,
	input wire       I_SMF_STB,
	input wire       I_SMF_SEL,
	input wire       I_SMF_CRC_ERR,
	input wire       O_REFRAME
);
	reg  [1:0] eb;
	reg  [1:0] sm;
	reg        a16;
	reg  [7:0] zc;
	wire       rd_sync  = I_RD && I_ADDR == 5'h10;
	wire       rd_alarm = I_RD && I_ADDR == 5'h11;
	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (!I_RST_N);
	// ----------------------------------------------------------------
	// shadows of the last captured framer values
	// ----------------------------------------------------------------
	always @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			eb  <= 2'h0;
			sm  <= 2'h0;
			a16 <= 1'b0;
			zc  <= 8'h00;
		end else begin
			if (I_EBIT_STB)
				eb <= {I_EBIT1, I_EBIT2};
			if (I_SMF_STB)
				sm[~I_SMF_SEL] <= I_SMF_CRC_ERR;
			if (I_FRAME_STB)
				a16 <= I_TS16_ONES;
			// saturates so a long zero run never wraps under 192
			if (I_BIT_STB)
				zc <= I_RX_BIT ? 8'h00 : zc + {7'h00, zc != 8'hFF};
		end
	end
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	rd_idle_a: assert property (!I_RD |=> O_RDATA == 8'h00)
		else $error("read data not zero when idle");
	frame_bit_a: assert property (rd_sync |=> O_RDATA[7] == !$past(I_BFA_OK))
		else $error("frame alignment bit wrong");
	align_bits_a: assert property (rd_sync |=> O_RDATA[6:5] == ~{$past(I_MFA_OK),
		$past(I_CRC_MFA_OK)}) else $error("multiframe alignment bits wrong");
	ebit_bits_a: assert property (rd_sync && !I_EBIT_STB |=> O_RDATA[4:3] == eb)
		else $error("e-bit status wrong");
	alarm_clear_a: assert property (rd_sync && I_BFA_OK && $past(I_BFA_OK) &&
		$past(I_BFA_OK, 2) |=> !O_RDATA[1]) else $error("frame loss alarm stuck");
	submf_bits_a: assert property (rd_alarm && !I_SMF_STB |=> O_RDATA[7:6] == sm)
		else $error("submultiframe error bits wrong");
	ts16_bit_a: assert property (rd_alarm && !I_FRAME_STB |=> O_RDATA[3] == a16)
		else $error("channel 16 alarm bit wrong");
	los_set_a: assert property (rd_alarm && zc >= 8'hC0 |=> O_RDATA[4])
		else $error("loss of signal not shown");
	reframe_pulse_a: assert property (O_REFRAME |-> !$past(I_CRC_MFA_OK) ##1 !O_REFRAME)
		else $error("reframe pulse wrong");
endmodule // ers_status_bank_props

bind ers_status_bank ers_status_bank_props i_props (
	.I_CLK, .I_RST_N, .I_ADDR, .I_RD, .O_RDATA, .I_BIT_STB, .I_RX_BIT, .I_FRAME_STB,
	.I_BFA_OK, .I_MFA_OK, .I_CRC_MFA_OK, .I_TS16_ONES, .I_EBIT_STB, .I_EBIT1,
	.I_EBIT2, .I_SMF_STB, .I_SMF_SEL, .I_SMF_CRC_ERR, .O_REFRAME
);

/* ers_line_model.sv */
/*
 * received line model: bit and frame strobes with a chosen ones density.
 * assumes the bench changes the mode between tests only.
 */
`timescale 1ns/1ps
module ers_line_model (
	// clock and reset
	input  wire       i_clk,
	input  wire       i_rst_n,
	// 0 zeros, 1 ones, 2 one in 8, 3 one in 16
	input  wire [1:0] i_mode,
	// line side
	output reg        o_bit_stb,
	output reg        o_rx_bit,
	output reg        o_frame_stb
);
	reg [7:0] cnt;
	// a bit every second clock, a frame every 16; data flips between strobes
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt         <= 8'h00;
			o_bit_stb   <= 1'b0;
			o_rx_bit    <= 1'b0;
			o_frame_stb <= 1'b0;
		end else begin
			cnt         <= cnt + 8'h01;
			o_bit_stb   <= cnt[0];
			o_frame_stb <= cnt[3:0] == 4'hF;
			if (cnt[0])
				o_rx_bit <= (i_mode == 2'h1) || (i_mode == 2'h2 && cnt[3:1] == 3'h0) ||
					(i_mode == 2'h3 && cnt[4:1] == 4'h0);
			else
				o_rx_bit <= ~o_rx_bit;
		end
	end
endmodule // ers_line_model

/* tb.sv */
/*
 * testbench for the e1 status bank: register tasks, line model, queued reads.
 * assumes the bank answers a read in the next cycle and never stalls.
 */
`timescale 1ns/1ps
module tb;
	localparam [7:0] ID  = 8'h3C; // arbitrary value
	localparam       SEC = 2400;  // clocks in one monitoring second
	reg          I_CLK, I_RST_N, I_WR, I_RD, rd_d, err_on;
	reg    [4:0] I_ADDR;
	reg    [7:0] I_WDATA, ctl;
	reg          I_BFA_OK, I_MFA_OK, I_CRC_MFA_OK, I_RAI, I_TS16_ONES;
	reg          I_EBIT_STB, I_EBIT1, I_EBIT2, I_EBIT_ERR;
	reg          I_SMF_STB, I_SMF_SEL, I_SMF_CRC_ERR;
	reg    [1:0] mode, sm;
	reg   [31:0] r;
	reg   [15:0] x;
	wire   [7:0] O_RDATA;
	wire         O_REFRAME, O_IRQ, I_BIT_STB, I_RX_BIT, I_FRAME_STB;
	integer      n_errors, checked, i, k, p, t;
	logic [15:0] q[$];

	ers_status_bank #(.FRAME_TICKS(4), .SEC_FRAMES(600), .DEVICE_ID(ID)) i_dut (
		.I_CLK, .I_RST_N, .I_ADDR, .I_WDATA, .I_WR, .I_RD, .O_RDATA, .I_BIT_STB,
		.I_RX_BIT, .I_FRAME_STB, .I_BFA_OK, .I_MFA_OK, .I_CRC_MFA_OK, .I_RAI,
		.I_TS16_ONES, .I_EBIT_STB, .I_EBIT1, .I_EBIT2, .I_EBIT_ERR, .I_SMF_STB,
		.I_SMF_SEL, .I_SMF_CRC_ERR, .O_REFRAME, .O_IRQ);
	ers_line_model i_line (.i_clk(I_CLK), .i_rst_n(I_RST_N), .i_mode(mode),
		.o_bit_stb(I_BIT_STB), .o_rx_bit(I_RX_BIT), .o_frame_stb(I_FRAME_STB));
	// ----------------------------------------------------------------
	// clock, error pulses and read checking
	// ----------------------------------------------------------------
	initial begin
		I_CLK = 1'b0;
		forever #2.5 I_CLK = ~I_CLK;
	end
	// every other cycle keeps the error rate above the limit per second
	always @(posedge I_CLK) I_EBIT_ERR <= err_on & ~I_EBIT_ERR;
	always @(posedge I_CLK) rd_d <= I_RD;
	// read data settle well before the falling edge
	always @(negedge I_CLK) begin
		if (rd_d) begin
			x = q.pop_front();
			checked = checked + 1;
			if ((O_RDATA & x[15:8]) !== (x[7:0] & x[15:8]))
				$display("FAIL %0t read %h want %h mask %h", $time, O_RDATA, x[7:0], x[15:8]);
			if ((O_RDATA & x[15:8]) !== (x[7:0] & x[15:8]))
				n_errors = n_errors + 1;
		end
	end
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task finish_test;
		begin
			$display("checks %0d errors %0d", checked, n_errors);
			if (n_errors == 0 && checked > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask
	task chk(input c, input [8*24-1:0] s);
		begin
			checked = checked + 1;
			if (c !== 1'b1) begin
				n_errors = n_errors + 1;
				$display("FAIL %0t %0s", $time, s);
			end
		end
	endtask
	task wt(input integer n);
		repeat (n) @(posedge I_CLK);
	endtask
	task wr(input [4:0] a, input [7:0] d);
		begin
			@(posedge I_CLK);
			I_ADDR  <= a;
			I_WDATA <= d;
			I_WR    <= 1'b1;
			@(posedge I_CLK);
			I_WR    <= 1'b0;
		end
	endtask
	task rd(input [4:0] a, input [7:0] e, input [7:0] m);
		begin
			@(posedge I_CLK);
			I_ADDR <= a;
			I_RD   <= 1'b1;
			q.push_back({m, e});
			@(posedge I_CLK);
			I_RD   <= 1'b0;
		end
	endtask
	// bounded wait for the interrupt level; a hang ends the run
	task wirq(input v);
		begin
			k = 0;
			@(negedge I_CLK);
			while (k < 8 && O_IRQ !== v) begin
				@(negedge I_CLK);
				k = k + 1;
			end
			chk(O_IRQ === v, "interrupt level");
			if (O_IRQ !== v)
				finish_test;
		end
	endtask
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		{I_RST_N, I_WR, I_RD, I_RAI, I_TS16_ONES, I_EBIT_STB, I_EBIT1, I_EBIT2} = 8'h00;
		{I_SMF_STB, I_SMF_SEL, I_SMF_CRC_ERR, err_on, sm} = 6'h00;
		{I_BFA_OK, I_MFA_OK, I_CRC_MFA_OK, I_ADDR, I_WDATA, mode} = 18'h38002;
		n_errors = 0;
		checked = 0;
		r = $urandom(32'h0215b66e);
		wt(16);
		I_RST_N <= 1'b1;
		// reset values, writes ignored, unmapped places read zero
		rd(5'h1A, 8'h04, 8'hFF);
		rd(5'h1D, 8'h00, 8'hFF);
		wr(5'h10, 8'hFF);
		wr(5'h11, 8'hFF);
		wr(5'h1F, 8'h00);
		rd(5'h10, 8'h00, 8'hFE);
		rd(5'h11, 8'h00, 8'hFF);
		rd(5'h1F, ID, 8'hFF);
		for (i = 0; i < 32; i = i + 1)
			if (i != 16 && i != 17 && i != 26 && i != 28 && i != 29 && i != 31)
				rd(i[4:0], 8'h00, 8'hFF);
		for (i = 0; i < 8; i = i + 1) begin
			@(posedge I_CLK);
			{I_BFA_OK, I_MFA_OK, I_CRC_MFA_OK} <= i[2:0];
			rd(5'h10, {~i[2:0], 5'h00}, 8'hE0);
		end
		{I_BFA_OK, I_MFA_OK, I_CRC_MFA_OK} <= 3'h7;
		for (i = 0; i < 4; i = i + 1) begin
			@(posedge I_CLK);
			{I_EBIT_STB, I_EBIT1, I_EBIT2} <= {1'b1, i[1:0]};
			@(posedge I_CLK);
			I_EBIT_STB <= 1'b0;
			rd(5'h10, {3'h0, i[1:0], 3'h0}, 8'h18);
		end
		for (i = 0; i < 8; i = i + 1) begin
			r = $urandom;
			sm[~r[1]] = r[0];
			@(posedge I_CLK);
			{I_SMF_STB, I_SMF_SEL, I_SMF_CRC_ERR} <= {1'b1, r[1:0]};
			@(posedge I_CLK);
			I_SMF_STB <= 1'b0;
			rd(5'h11, {sm, 6'h00}, 8'hC0);
		end
		I_TS16_ONES <= 1'b1;
		wt(40);
		rd(5'h11, 8'h08, 8'h08);
		I_TS16_ONES <= 1'b0;
		wt(40);
		rd(5'h11, 8'h00, 8'h08);
		// reframe with maintenance and interworking settings in turn
		for (i = 0; i < 3; i = i + 1) begin
			ctl = (i == 0) ? 8'h02 : (i == 1) ? 8'h06 : 8'h00;
			wr(5'h1A, ctl);
			I_CRC_MFA_OK <= 1'b1;
			wt(4);
			rd(5'h10, 8'h01, 8'h05);
			{I_CRC_MFA_OK, I_BFA_OK} <= 2'h0;
			wt(4);
			I_BFA_OK <= 1'b1;
			p = 0;
			t = 0;
			for (k = 0; k < 300; k = k + 1) begin
				@(negedge I_CLK);
				if (O_REFRAME === 1'b1) begin
					p = p + 1;
					t = k;
				end
			end
			chk(i == 0 ? (p == 1 && t >= 248 && t <= 268) : p == 0, "reframe pulse");
			rd(5'h10, {5'h00, 2'h2, i != 1}, 8'h07);
		end
		I_CRC_MFA_OK <= 1'b1;
		wr(5'h1A, 8'h04);
		// frame loss alarm only after the full hold time
		I_BFA_OK <= 1'b0;
		wt(3090);
		rd(5'h10, 8'h00, 8'h02);
		wt(200);
		rd(5'h10, 8'h02, 8'h02);
		I_BFA_OK <= 1'b1;
		wt(2);
		rd(5'h10, 8'h00, 8'h02);
		// loss of signal, sticky status, clear and mask
		wr(5'h1D, 8'hFF);
		wr(5'h1C, 8'hFF);
		wirq(1'b0);
		mode <= 2'h0;
		wt(420);
		rd(5'h11, 8'h10, 8'h10);
		rd(5'h1C, 8'h20, 8'h20);
		wirq(1'b1);
		mode <= 2'h3;
		wt(1000);
		rd(5'h11, 8'h10, 8'h10);
		mode <= 2'h2;
		wt(1000);
		rd(5'h11, 8'h00, 8'h10);
		wr(5'h1C, 8'h20);
		rd(5'h1C, 8'h00, 8'h20);
		wirq(1'b0);
		wr(5'h1D, 8'h00);
		mode <= 2'h0;
		wt(420);
		rd(5'h1C, 8'h20, 8'h20);
		wirq(1'b0);
		mode <= 2'h2;
		wt(1000);
		// all-ones detection under both criteria
		for (i = 0; i < 2; i = i + 1) begin
			wr(5'h1A, 8'h04 | i[7:0]);
			mode <= 2'h1;
			wt(2200);
			rd(5'h11, 8'h04, 8'h04);
			rd(5'h1C, 8'h80, 8'h80);
			mode <= 2'h2;
			wt(2200);
			rd(5'h11, 8'h00, 8'h04);
			wr(5'h1C, 8'h80);
		end
		// remote failure needs five whole good seconds in a row
		err_on <= 1'b1;
		wt(SEC * 3 + SEC / 2);
		rd(5'h11, 8'h00, 8'h20);
		wt(SEC * 3);
		rd(5'h11, 8'h20, 8'h20);
		I_RAI <= 1'b1;
		wt(1);
		I_RAI <= 1'b0;
		wt(SEC * 2 + 100);
		rd(5'h11, 8'h00, 8'h20);
		wt(4);
		finish_test;
	end
endmodule // tb
